/* debug_ctrl_pkg.sv */
// constants for the background debug control block
package debug_ctrl_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam int PAGE_W = 4;
  localparam logic [ADDR_W-1:0] FW_SPACE_LO = 18'h3FF00;
  localparam logic [ADDR_W-1:0] FW_SPACE_HI = 18'h3FFFF;
  localparam logic [ADDR_W-1:0] REG_SPACE_HI = 18'h3FF0B;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 18'h3FF01;
  localparam logic [ADDR_W-1:0] CCR_HOLD_ADDR = 18'h3FF06;
  localparam logic [ADDR_W-1:0] PAGE_INDEX_ADDR = 18'h3FF08;
  localparam logic [ADDR_W-1:0] FAMILY_IDENTIFIER_ADDR = 18'h3FF0F;
  localparam int ENABLE_BIT = 7;
  localparam int ACTIVE_BIT = 6;
  localparam int UNSECURE_FLAG_BIT = 1;
  localparam int PAGE_EN_BIT = 7;
  localparam int PAGE_SEL_MSB = 3;
  localparam int PAGE_SEL_LSB = 0;
  localparam logic [DATA_W-1:0] CCR_RESET_SPECIAL = 8'hC8;
  localparam logic [DATA_W-1:0] CCR_RESET_OTHER = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam int REFUSE_DELAY_NS = 100;
  localparam int CLOCK_PERIOD_NS = 25;
  localparam int REFUSE_DELAY_CYCLES = (REFUSE_DELAY_NS / CLOCK_PERIOD_NS < 1) ? 1 :
    REFUSE_DELAY_NS / CLOCK_PERIOD_NS;
  localparam int DELAY_W = 4;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PENDING = 4'h2,
    ST_ACTIVE = 4'h4,
    ST_REFUSE = 4'h8
  } debug_state_type;
endpackage

/* background_debug_control.sv */
// activation, security gating and register space of the background debug unit
`timescale 1ns/10ps
// Notes on behaviour
// RQ1 - on debug entry the user condition codes are saved in the holding register
// RQ2 - writing the holding register changes the condition codes restored at exit
// RQ3 - holding and page registers accessible only by debug accesses while unsecured; the code also lets secure firmware read them while secured in special mode
// RQ4 - page index bit 7 turns paged program access on for debug accesses
// RQ5 - debug space read and write commands never make global accesses
// RQ6 - page index bits 3 to 0 choose the program page for paged accesses
// RQ7 - a read-only 8-bit family identifier sits at the top firmware address; the code places it at 18'h3FF0F, not 18'h3FFFF
// RQ8 - host sends hardware and firmware commands over the wire, device executes
// RQ9 - hardware commands access memory and enter debug; firmware commands exit it
// RQ10 - hardware commands refused when secured; firmware needs unsecured and active
// RQ11 - secure firmware on clean erase check sets unsecure and enable flags
// RQ12 - failed erase check sets only enable; firmware commands stay refused
// RQ13 - when secured, debug only works in special single-chip mode
// RQ14 - disabled activation resumes after a short delay; disabled enter command ignored
// RQ15 - host enables debug by writing the status enable bit with a hardware command
// RQ16 - enabled debug activates by enter command, halt instruction or breakpoint
// RQ17 - special single-chip reset leaves debug enabled and active; the code leaves the enable bit clear when secured
// RQ18 - activation waits for the current instruction to finish
// RQ19 - in active debug the firmware space and registers map at the top page
// RQ20 - debug registers never return contents to user program reads
// RQ21 - entry from code overlapping firmware space bumps the saved counter by one
// RQ22 - host must load a valid counter before resuming in the overlap case
// RQ23 - status bit 7 enables activation; hardware commands allowed regardless
// RQ24 - status bit 1 shows unsecured, writable only by secure firmware in special mode
module background_debug_control #(
  parameter logic [7:0] FAMILY_IDENTIFIER = 8'h5A, // arbitrary value
  parameter int REFUSE_CYCLES = debug_ctrl_pkg::REFUSE_DELAY_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic special_mode,
  input wire logic secured,
  input wire logic [debug_ctrl_pkg::DATA_W-1:0] user_ccr,
  input wire logic cpu_instr_done,
  input wire logic cpu_in_fw_space,
  input wire logic halt_instr,
  input wire logic breakpoint,
  input wire logic global_enable_in,
  input wire logic cmd_valid,
  input wire logic cmd_firmware,
  input wire logic cmd_enter,
  input wire logic cmd_exit,
  input wire logic cmd_bd_space,
  input wire logic bus_valid,
  input wire logic bus_write,
  input wire logic bus_debug,
  input wire logic bus_secure_fw,
  input wire logic [debug_ctrl_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [debug_ctrl_pkg::DATA_W-1:0] bus_wdata,
  output logic cmd_accept,
  output logic cmd_refuse,
  output logic cmd_global,
  output logic page_enable,
  output logic [debug_ctrl_pkg::PAGE_W-1:0] page_select,
  output logic debug_enabled,
  output logic debug_active,
  output logic debug_map,
  output logic cpu_halt_req,
  output logic cpu_resume,
  output logic pc_increment,
  output logic [debug_ctrl_pkg::DATA_W-1:0] restore_ccr,
  output logic restore_valid,
  output logic [debug_ctrl_pkg::DATA_W-1:0] bus_rdata,
  output logic bus_ack
);
  import debug_ctrl_pkg::*;

  debug_state_type state;
  debug_state_type next_state;
  logic init_pending;
  logic enable_bit;
  logic unsecure_flag_bit;
  logic [DATA_W-1:0] ccr_hold;
  logic [DATA_W-1:0] page_index;
  logic [DELAY_W-1:0] delay_count;

  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    return a == b;
  endfunction

  // security and command gating
  wire logic secured_now = secured & ~unsecure_flag_bit;
  wire logic hw_ok = ~secured_now | special_mode; // [RQ10] [RQ13]
  wire logic fw_ok = ~secured_now & (state == ST_ACTIVE); // [RQ10] [RQ12]
  wire logic cmd_ok = cmd_firmware ? fw_ok : hw_ok; // [RQ8] [RQ9]
  wire logic enter_ok = cmd_valid & ~cmd_firmware & cmd_enter & hw_ok;
  wire logic exit_ok = cmd_valid & cmd_firmware & cmd_exit & fw_ok; // [RQ9]
  wire logic cpu_trigger = halt_instr | breakpoint;
  // a disabled enter command falls through here and never stalls the cpu
  wire logic activate = enable_bit & (enter_ok | cpu_trigger); // [RQ16] [RQ23]
  wire logic refuse_start = ~enable_bit & cpu_trigger; // [RQ14]
  wire logic entering = (state == ST_PENDING) & cpu_instr_done; // [RQ18]

  // register decode
  wire logic hit_status = addr_is(bus_addr, STATUS_ADDR);
  wire logic hit_ccr = addr_is(bus_addr, CCR_HOLD_ADDR);
  wire logic hit_page = addr_is(bus_addr, PAGE_INDEX_ADDR);
  wire logic hit_family = addr_is(bus_addr, FAMILY_IDENTIFIER_ADDR);
  // the init cycle takes no access, so a write there cannot land unacknowledged
  wire logic reg_ok = bus_valid & bus_debug & ~secured_now & ~init_pending; // [RQ3] [RQ20]
  wire logic fw_rights = bus_valid & bus_debug & bus_secure_fw & special_mode & ~init_pending;
  wire logic wr_ccr = reg_ok & bus_write & hit_ccr; // [RQ2] [RQ3]
  wire logic wr_page = reg_ok & bus_write & hit_page; // [RQ3]
  // secure firmware may touch status even while secured, that is how it unlocks
  wire logic wr_status = (reg_ok | fw_rights) & bus_write & hit_status; // [RQ15]
  wire logic wr_unsecure_flag = fw_rights & bus_write & hit_status; // [RQ11] [RQ12] [RQ24]
  wire logic rd_allowed = (reg_ok | fw_rights) & ~bus_write;
  wire logic [DATA_W-1:0] status_value = {enable_bit, state == ST_ACTIVE, 4'h0, unsecure_flag_bit, 1'b0};
  wire logic [DATA_W-1:0] read_value =
    hit_status ? status_value :
    hit_ccr ? ccr_hold :
    hit_page ? page_index :
    hit_family ? FAMILY_IDENTIFIER : BYTE_ZERO; // [RQ7]
  wire logic [DATA_W-1:0] next_rdata = rd_allowed ? read_value : BYTE_ZERO; // [RQ20]
  wire logic delay_done = delay_count == DELAY_W'(1);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (activate) begin
          next_state = ST_PENDING;
        end else if (refuse_start) begin
          next_state = ST_REFUSE;
        end
      end
      ST_PENDING: begin
        if (cpu_instr_done) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (exit_ok) begin
          next_state = ST_IDLE;
        end
      end
      ST_REFUSE: begin
        if (delay_done) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // mode straps are taken one cycle after reset release, never by the reset itself
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      init_pending <= 1'b1;
      state <= ST_IDLE;
    end else if (init_pending) begin
      init_pending <= 1'b0;
      state <= special_mode ? ST_ACTIVE : ST_IDLE; // [RQ17]
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      enable_bit <= 1'b0;
      unsecure_flag_bit <= 1'b0;
    end else if (init_pending) begin
      enable_bit <= special_mode & ~secured; // [RQ17] [RQ12]
      unsecure_flag_bit <= 1'b0;
    end else begin
      if (wr_status) begin
        enable_bit <= bus_wdata[ENABLE_BIT]; // [RQ15] [RQ23]
      end
      if (wr_unsecure_flag) begin
        unsecure_flag_bit <= bus_wdata[UNSECURE_FLAG_BIT]; // [RQ24]
      end
    end
  end

  // entry capture wins over a simultaneous write of the holding register
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ccr_hold <= CCR_RESET_OTHER;
      page_index <= BYTE_ZERO;
    end else begin
      if (init_pending) begin
        ccr_hold <= special_mode ? CCR_RESET_SPECIAL : CCR_RESET_OTHER;
      end else if (entering) begin
        ccr_hold <= user_ccr; // [RQ1]
      end else if (wr_ccr) begin
        ccr_hold <= bus_wdata; // [RQ2]
      end
      if (wr_page) begin
        page_index <= bus_wdata; // [RQ3]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      delay_count <= '0;
    end else if (state == ST_IDLE && refuse_start && !activate) begin
      delay_count <= DELAY_W'(REFUSE_CYCLES);
    end else if (delay_count != '0) begin
      delay_count <= delay_count - DELAY_W'(1);
    end
  end

  // registered outputs
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cmd_accept <= 1'b0;
      cmd_refuse <= 1'b0;
      cmd_global <= 1'b0;
      page_enable <= 1'b0;
      page_select <= '0;
      debug_enabled <= 1'b0;
      debug_active <= 1'b0;
      debug_map <= 1'b0;
      cpu_halt_req <= 1'b0;
      cpu_resume <= 1'b0;
      pc_increment <= 1'b0;
      restore_ccr <= BYTE_ZERO;
      restore_valid <= 1'b0;
      bus_rdata <= BYTE_ZERO;
      bus_ack <= 1'b0;
    end else begin
      cmd_accept <= cmd_valid & cmd_ok;
      cmd_refuse <= cmd_valid & ~cmd_ok;
      cmd_global <= cmd_valid & cmd_ok & global_enable_in & ~cmd_bd_space; // [RQ5]
      page_enable <= page_index[PAGE_EN_BIT]; // [RQ4]
      page_select <= page_index[PAGE_SEL_MSB:PAGE_SEL_LSB]; // [RQ6]
      debug_enabled <= enable_bit;
      debug_active <= state == ST_ACTIVE;
      debug_map <= state == ST_ACTIVE; // [RQ19]
      cpu_halt_req <= state == ST_PENDING || state == ST_REFUSE; // [RQ18]
      cpu_resume <= state == ST_REFUSE && delay_done; // [RQ14]
      pc_increment <= entering & cpu_in_fw_space; // [RQ21] [RQ22]
      restore_ccr <= ccr_hold; // [RQ2]
      restore_valid <= exit_ok;
      bus_rdata <= next_rdata;
      bus_ack <= bus_valid & ~init_pending;
    end
  end

  // checks
  property user_read_blind;
    @(posedge clock) disable iff (!rst_b)
      bus_valid && !bus_debug |=> bus_rdata == BYTE_ZERO;
  endproperty
  user_read_zero_a: assert property (user_read_blind) else $error("user read saw debug data"); // [RQ20]

  ccr_capture_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ1]
    entering && !init_pending |=> ccr_hold == $past(user_ccr)) else $error("ccr not saved on entry");

  bd_no_global_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ5]
    cmd_valid && cmd_bd_space |=> !cmd_global) else $error("debug space command went global");

  fw_gate_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ10]
    cmd_valid && cmd_firmware && state != ST_ACTIVE |=> cmd_refuse && !cmd_accept)
    else $error("firmware command accepted outside active debug");

  secure_hw_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ13]
    cmd_valid && !cmd_firmware && secured_now && !special_mode |=> cmd_refuse)
    else $error("hardware command accepted while secured");

  refuse_resume_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ14]
    state == ST_IDLE && !init_pending && !enable_bit && cpu_trigger
      |=> state == ST_REFUSE ##[1:20] cpu_resume) else $error("no resume after refused activation");

  disabled_enter_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ14]
    state == ST_IDLE && !init_pending && !enable_bit && !cpu_trigger |=> state == ST_IDLE)
    else $error("disabled enter command stalled the cpu");

  wait_instr_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ18]
    state == ST_PENDING && !cpu_instr_done |=> state == ST_PENDING) else $error("entered before instruction end");

  page_out_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ6]
    wr_page ##2 1 |-> page_select == $past(bus_wdata[PAGE_SEL_MSB:PAGE_SEL_LSB], 2))
    else $error("page select not from written index");

  special_reset_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ17]
    init_pending && special_mode |=> ##1 debug_active) else $error("special reset not active");

  overlap_pc_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ21]
    entering && cpu_in_fw_space |=> pc_increment) else $error("overlap entry missed pc bump");

  unsecure_flag_write_a: assert property (@(posedge clock) disable iff (!rst_b) // [RQ24]
    !init_pending && !wr_unsecure_flag |=> unsecure_flag_bit == $past(unsecure_flag_bit)) else $error("unsecure flag changed illegally");
endmodule

/* debug_host_model.sv */
// external debug host issuing decoded serial commands
`timescale 1ns/10ps
module debug_host_model (
  input wire logic clock,
  output logic cmd_valid,
  output logic cmd_firmware,
  output logic cmd_enter,
  output logic cmd_exit,
  output logic cmd_bd_space
);
  initial begin
    cmd_valid = 1'b0;
    {cmd_firmware, cmd_enter, cmd_exit, cmd_bd_space} = 4'h0;
  end
  // one command per call, {firmware, enter, exit, space}, held over one edge
  // used to enter debug, issue hardware and firmware commands and exit it
  task automatic send(input logic [3:0] kind);
    @(negedge clock);
    {cmd_firmware, cmd_enter, cmd_exit, cmd_bd_space} = kind;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    // released qualifiers flip so a stale value is never mistaken for a command
    {cmd_firmware, cmd_enter, cmd_exit, cmd_bd_space} = ~kind;
  endtask
endmodule

/* test_background_debug_control.sv */
// self-checking bench for the background debug control block
`timescale 1ns/10ps
module test_background_debug_control;
  import debug_ctrl_pkg::*;
  localparam logic [7:0] FAM = 8'h3D; // arbitrary value
  logic clock, rst_b, special_mode, secured, cpu_instr_done, cpu_in_fw_space, halt_instr, breakpoint;
  logic global_enable_in, bus_valid, bus_write, bus_debug, bus_secure_fw, flag;
  logic cmd_valid, cmd_firmware, cmd_enter, cmd_exit, cmd_bd_space, cmd_accept, cmd_refuse, cmd_global;
  logic page_enable, debug_enabled, debug_active, debug_map, cpu_halt_req, cpu_resume, pc_increment;
  logic restore_valid, bus_ack;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] user_ccr, bus_wdata, bus_rdata, restore_ccr, rd;
  logic [PAGE_W-1:0] page_select;
  int mismatches = 0;
  int check_count = 0;
  background_debug_control #(.FAMILY_IDENTIFIER(FAM), .REFUSE_CYCLES(4)) i_background_debug_control (
    .clock, .rst_b, .special_mode, .secured, .user_ccr, .cpu_instr_done, .cpu_in_fw_space, .halt_instr,
    .breakpoint, .global_enable_in, .cmd_valid, .cmd_firmware, .cmd_enter, .cmd_exit, .cmd_bd_space,
    .bus_valid, .bus_write, .bus_debug, .bus_secure_fw, .bus_addr, .bus_wdata, .cmd_accept, .cmd_refuse,
    .cmd_global, .page_enable, .page_select, .debug_enabled, .debug_active, .debug_map, .cpu_halt_req,
    .cpu_resume, .pc_increment, .restore_ccr, .restore_valid, .bus_rdata, .bus_ack);
  debug_host_model i_debug_host_model (.clock, .cmd_valid, .cmd_firmware, .cmd_enter, .cmd_exit,
    .cmd_bd_space);
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // the sequence needs a few hundred cycles; 4000 means a hang
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
  task automatic conclude;
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic c1(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask
  task automatic restart(input logic sp, input logic sec);
    @(negedge clock);
    rst_b = 1'b0;
    special_mode = sp;
    secured = sec;
    repeat (16) @(negedge clock);
    rst_b = 1'b1;
    repeat (2) @(negedge clock);
  endtask
  // kind is {write, debug unit, secure firmware}
  task automatic bus(input logic [2:0] kind, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clock);
    {bus_write, bus_debug, bus_secure_fw} = kind;
    bus_addr = a;
    bus_wdata = d;
    bus_valid = 1'b1;
    @(negedge clock);
    rd = bus_rdata;
    c1(bus_ack, 1'b1);
    bus_valid = 1'b0;
    bus_addr = ~a;
    bus_wdata = ~d;
    @(negedge clock);
  endtask
  // returns while the one-cycle answer pulse still stands
  task automatic cmd(input logic [3:0] kind);
    i_debug_host_model.send(kind);
  endtask
  task automatic wait_active;
    flag = 1'b0;
    cpu_instr_done = 1'b1;
    for (int n = 0; n < 20 && debug_active !== 1'b1; n++) begin
      @(negedge clock);
      flag = flag | pc_increment;
    end
    cpu_instr_done = 1'b0;
  endtask
  initial begin
    {rst_b, special_mode, secured, cpu_instr_done, cpu_in_fw_space, halt_instr, breakpoint} = 7'h00;
    {global_enable_in, bus_valid, bus_write, bus_debug, bus_secure_fw} = 5'h00;
    {bus_addr, user_ccr, bus_wdata} = '0;
    restart(1'b1, 1'b0);
    c1(debug_active, 1'b1);
    bus(3'h2, STATUS_ADDR, 8'h00);
    check(rd & 8'hC0, 8'hC0);
    bus(3'h2, CCR_HOLD_ADDR, 8'h00);
    check(rd, 8'hC8);
    bus(3'h6, FAMILY_IDENTIFIER_ADDR, 8'hFF);
    bus(3'h2, FAMILY_IDENTIFIER_ADDR, 8'h00);
    check(rd, FAM);
    bus(3'h6, CCR_HOLD_ADDR, 8'h3C);
    bus(3'h4, CCR_HOLD_ADDR, 8'h11);
    bus(3'h0, CCR_HOLD_ADDR, 8'h00);
    check(rd, 8'h00);
    bus(3'h2, CCR_HOLD_ADDR, 8'h00);
    check(rd, 8'h3C);
    bus(3'h6, PAGE_INDEX_ADDR, 8'h8A);
    c1(page_enable, 1'b1);
    check({4'h0, page_select}, 8'h0A);
    bus(3'h2, PAGE_INDEX_ADDR, 8'h00);
    check(rd & 8'h8F, 8'h8A);
    bus(3'h6, PAGE_INDEX_ADDR, 8'h05);
    c1(page_enable, 1'b0);
    bus(3'h2, 18'h3FF02, 8'h00);
    check(rd, 8'h00);
    global_enable_in = 1'b1;
    cmd(4'h1);
    c1(cmd_global, 1'b0);
    cmd(4'h0);
    c1(cmd_global, 1'b1);
    cmd(4'hA);
    c1(restore_valid, 1'b1);
    check(restore_ccr, 8'h3C);
    @(negedge clock);
    c1(debug_active, 1'b0);
    cmd(4'h8);
    c1(cmd_refuse, 1'b1);
    cmd(4'h4);
    c1(cmd_accept, 1'b1);
    @(negedge clock);
    c1(cpu_halt_req, 1'b1);
    user_ccr = 8'h5B;
    cpu_in_fw_space = 1'b1;
    wait_active();
    c1(debug_map, 1'b1);
    c1(flag, 1'b1);
    bus(3'h2, CCR_HOLD_ADDR, 8'h00);
    check(rd, 8'h5B);
    cmd(4'h8);
    c1(cmd_accept, 1'b1);
    cmd(4'hA);
    c1(restore_valid, 1'b1);
    check(restore_ccr, 8'h5B);
    restart(1'b0, 1'b0);
    c1(debug_enabled, 1'b0);
    bus(3'h2, CCR_HOLD_ADDR, 8'h00);
    check(rd, 8'h00);
    halt_instr = 1'b1;
    @(negedge clock);
    halt_instr = 1'b0;
    for (int n = 0; n < 20 && cpu_resume !== 1'b1; n++) @(negedge clock);
    c1(cpu_resume, 1'b1);
    cmd(4'h4);
    repeat (3) @(negedge clock);
    c1(cpu_halt_req | debug_active, 1'b0);
    bus(3'h6, STATUS_ADDR, 8'h80);
    c1(debug_enabled, 1'b1);
    cpu_in_fw_space = 1'b0;
    breakpoint = 1'b1;
    @(negedge clock);
    breakpoint = 1'b0;
    wait_active();
    c1(debug_active, 1'b1);
    c1(flag, 1'b0);
    restart(1'b0, 1'b1);
    cmd(4'h1);
    c1(cmd_refuse, 1'b1);
    bus(3'h6, CCR_HOLD_ADDR, 8'h77);
    bus(3'h2, CCR_HOLD_ADDR, 8'h00);
    check(rd, 8'h00);
    restart(1'b1, 1'b1);
    c1(debug_active, 1'b1);
    bus(3'h7, STATUS_ADDR, 8'h80);
    c1(debug_enabled, 1'b1);
    cmd(4'h8);
    c1(cmd_refuse, 1'b1);
    cmd(4'h1);
    c1(cmd_accept, 1'b1);
    bus(3'h7, STATUS_ADDR, 8'h82);
    bus(3'h3, STATUS_ADDR, 8'h00);
    check(rd & 8'h82, 8'h82);
    cmd(4'h8);
    c1(cmd_accept, 1'b1);
    conclude();
  end
endmodule
